/* pkg/eeprom_pkg.sv */
package eeprom_pkg;

  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_PERIOD_NS = 20;

  // Least noise suppression time, rounded up to whole clock cycles.
  localparam int FILTER_NS = 250;
  localparam int FILTER_CYCLES = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Erase/write time for one byte; two bytes take twice as long.
  localparam int EW_BYTE_MS = 20;
  localparam int EW_BYTE_CYCLES = EW_BYTE_MS * (CLK_HZ / 1000);

  localparam int MEM_WORDS = 256;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int MAX_WRITE_BYTES = 2;
  localparam int STRAP_W = 3;

  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [ADDR_W-1:0] PTR_RESET = 8'h00;
  localparam logic [1:0] WR_CNT_RESET = 2'h0;
  localparam logic SCL_IDLE = 1'b1;
  localparam logic SDA_IDLE = 1'b1;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RX = 5'b00010,
    ST_RX_ACK = 5'b00100,
    ST_TX = 5'b01000,
    ST_TX_ACK = 5'b10000
  } state_t;

  typedef enum logic [1:0] {
    KIND_SLAVE = 2'h0,
    KIND_WORD = 2'h1,
    KIND_DATA = 2'h2
  } rx_kind_t;

endpackage : eeprom_pkg

/* logic/pin_filter.sv */
`timescale 1ns/1ps

module pin_filter #(
  parameter int STABLE_CYCLES = eeprom_pkg::FILTER_CYCLES,
  parameter logic RESET_LEVEL = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_ni,
  input wire logic raw_i,
  output logic filt_o
);

  localparam int CNT_W = $clog2(STABLE_CYCLES + 1);

  initial begin
    if (STABLE_CYCLES < 1) begin
      $error("pin_filter needs at least one stable cycle");
    end
  end

  logic meta_q;
  logic sync_q;
  logic [CNT_W-1:0] cnt_q;

  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      meta_q <= RESET_LEVEL;
      sync_q <= RESET_LEVEL;
    end else begin
      meta_q <= raw_i;
      sync_q <= meta_q;
    end
  end

  // A new level is taken only after it has stood for the whole window.
  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      cnt_q <= '0;
      filt_o <= RESET_LEVEL;
    end else if (sync_q == filt_o) begin
      cnt_q <= '0;
    end else if (cnt_q == CNT_W'(STABLE_CYCLES - 1)) begin
      cnt_q <= '0;
      filt_o <= sync_q;
    end else begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

endmodule : pin_filter

/* logic/serial_eeprom_i2c_slave.sv */
`timescale 1ns/1ps

module serial_eeprom_i2c_slave #(
  parameter int EW_BYTE_CYCLES = eeprom_pkg::EW_BYTE_CYCLES
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [eeprom_pkg::STRAP_W-1:0] chip_select_straps_i,
  output logic busy_o
);

  localparam int AW = eeprom_pkg::ADDR_W;
  localparam int DW = eeprom_pkg::DATA_W;
  localparam int SW = eeprom_pkg::STRAP_W;

  initial begin
    if (EW_BYTE_CYCLES < 1) $error("erase/write time must be at least one cycle");
  end

  function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] p);
    ptr_next = p + AW'(1);
  endfunction : ptr_next

  logic rst_meta_q;
  logic rst_n;
  logic scl;
  logic sda;
  logic scl_prev_q;
  logic sda_prev_q;
  logic [SW-1:0] strap_meta_q;
  logic [SW-1:0] strap_q;

  eeprom_pkg::state_t state_q;
  eeprom_pkg::rx_kind_t kind_q;
  logic [3:0] bit_cnt_q;
  logic [DW-1:0] shift_q;
  logic read_q;
  logic master_ack_q;
  logic [AW-1:0] ptr_q;
  logic [AW-1:0] wr_addr_q;
  logic [DW-1:0] wr_buf_q [eeprom_pkg::MAX_WRITE_BYTES];
  logic [1:0] wr_cnt_q;
  logic [31:0] ew_cnt_q;
  logic [31:0] ew_target_q;
  logic [DW-1:0] mem_q [eeprom_pkg::MEM_WORDS];
  logic [1:0] commit_cnt_q;

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic ew_done;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  pin_filter #(
    .STABLE_CYCLES(eeprom_pkg::FILTER_CYCLES),
    .RESET_LEVEL(eeprom_pkg::SCL_IDLE)
  ) u_scl_filter (
    .clk_i(clk_i),
    .rst_ni(rst_n),
    .raw_i(scl_i),
    .filt_o(scl)
  );

  pin_filter #(
    .STABLE_CYCLES(eeprom_pkg::FILTER_CYCLES),
    .RESET_LEVEL(eeprom_pkg::SDA_IDLE)
  ) u_sda_filter (
    .clk_i(clk_i),
    .rst_ni(rst_n),
    .raw_i(sda_i),
    .filt_o(sda)
  );

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      scl_prev_q <= eeprom_pkg::SCL_IDLE;
      sda_prev_q <= eeprom_pkg::SDA_IDLE;
      strap_meta_q <= '0;
      strap_q <= '0;
    end else begin
      scl_prev_q <= scl;
      sda_prev_q <= sda;
      strap_meta_q <= chip_select_straps_i;
      strap_q <= strap_meta_q;
    end
  end

  assign scl_rise = scl && !scl_prev_q;
  assign scl_fall = !scl && scl_prev_q;
  assign start_det = scl && scl_prev_q && sda_prev_q && !sda;
  assign stop_det = scl && scl_prev_q && !sda_prev_q && sda;
  assign ew_done = busy_o && (ew_cnt_q == ew_target_q - 32'h1);

  // Bus protocol engine.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= eeprom_pkg::ST_IDLE;
      kind_q <= eeprom_pkg::KIND_SLAVE;
      bit_cnt_q <= '0;
      shift_q <= '0;
      read_q <= 1'b0;
      master_ack_q <= 1'b0;
      ptr_q <= eeprom_pkg::PTR_RESET;
      wr_addr_q <= eeprom_pkg::PTR_RESET;
      wr_cnt_q <= eeprom_pkg::WR_CNT_RESET;
      wr_buf_q[0] <= '0;
      wr_buf_q[1] <= '0;
      sda_oe_o <= 1'b0;
    end else if (start_det) begin
      state_q <= eeprom_pkg::ST_RX;
      kind_q <= eeprom_pkg::KIND_SLAVE;
      bit_cnt_q <= '0;
      sda_oe_o <= 1'b0;
    end else if (stop_det) begin
      state_q <= eeprom_pkg::ST_IDLE;
      sda_oe_o <= 1'b0;
      wr_cnt_q <= eeprom_pkg::WR_CNT_RESET;
    end else begin
      case (state_q)
        eeprom_pkg::ST_IDLE: begin
          sda_oe_o <= 1'b0;
        end
        eeprom_pkg::ST_RX: begin
          if (scl_rise) begin
            shift_q <= {shift_q[DW-2:0], sda};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall && bit_cnt_q == eeprom_pkg::BIT_LAST) begin
            case (kind_q)
              eeprom_pkg::KIND_SLAVE: begin
                if (shift_q[SW:1] == strap_q && !busy_o) begin
                  read_q <= shift_q[0];
                  state_q <= eeprom_pkg::ST_RX_ACK;
                  sda_oe_o <= 1'b1;
                end else begin
                  state_q <= eeprom_pkg::ST_IDLE;
                end
              end
              eeprom_pkg::KIND_WORD: begin
                ptr_q <= shift_q;
                wr_addr_q <= shift_q;
                wr_cnt_q <= eeprom_pkg::WR_CNT_RESET;
                state_q <= eeprom_pkg::ST_RX_ACK;
                sda_oe_o <= 1'b1;
              end
              default: begin
                if (wr_cnt_q < 2'(eeprom_pkg::MAX_WRITE_BYTES)) begin
                  wr_buf_q[wr_cnt_q[0]] <= shift_q;
                  wr_cnt_q <= wr_cnt_q + 2'h1;
                  ptr_q <= ptr_next(ptr_q);
                  state_q <= eeprom_pkg::ST_RX_ACK;
                  sda_oe_o <= 1'b1;
                end else begin
                  state_q <= eeprom_pkg::ST_IDLE;
                end
              end
            endcase
          end
        end
        eeprom_pkg::ST_RX_ACK: begin
          if (scl_fall) begin
            bit_cnt_q <= '0;
            if (kind_q == eeprom_pkg::KIND_SLAVE && read_q) begin
              shift_q <= mem_q[ptr_q];
              sda_oe_o <= !mem_q[ptr_q][DW-1];
              state_q <= eeprom_pkg::ST_TX;
            end else begin
              sda_oe_o <= 1'b0;
              state_q <= eeprom_pkg::ST_RX;
              kind_q <= (kind_q == eeprom_pkg::KIND_SLAVE) ? eeprom_pkg::KIND_WORD
                                                           : eeprom_pkg::KIND_DATA;
            end
          end
        end
        eeprom_pkg::ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_q == eeprom_pkg::BIT_LAST - 4'h1) begin
              sda_oe_o <= 1'b0;
              state_q <= eeprom_pkg::ST_TX_ACK;
            end else begin
              shift_q <= {shift_q[DW-2:0], 1'b0};
              sda_oe_o <= !shift_q[DW-2];
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
          end
        end
        eeprom_pkg::ST_TX_ACK: begin
          if (scl_rise) begin
            master_ack_q <= !sda;
            if (!sda) begin
              ptr_q <= ptr_next(ptr_q);
            end
          end else if (scl_fall) begin
            bit_cnt_q <= '0;
            if (master_ack_q) begin
              shift_q <= mem_q[ptr_q];
              sda_oe_o <= !mem_q[ptr_q][DW-1];
              state_q <= eeprom_pkg::ST_TX;
            end else begin
              sda_oe_o <= 1'b0;
              state_q <= eeprom_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          state_q <= eeprom_pkg::ST_IDLE;
          sda_oe_o <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  // Self-timed erase/write cycle, launched by STOP.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      busy_o <= 1'b0;
      ew_cnt_q <= '0;
      ew_target_q <= 32'h1;
    end else if (!busy_o) begin
      if (stop_det && wr_cnt_q != 2'h0) begin
        busy_o <= 1'b1;
        ew_cnt_q <= '0;
        ew_target_q <= (wr_cnt_q == 2'h2) ? 32'(2 * EW_BYTE_CYCLES)
                                          : 32'(EW_BYTE_CYCLES);
      end
    end else if (ew_done) begin
      busy_o <= 1'b0;
    end else begin
      ew_cnt_q <= ew_cnt_q + 32'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      commit_cnt_q <= '0;
    end else if (!busy_o && stop_det) begin
      commit_cnt_q <= wr_cnt_q;
    end
  end

  // The array takes the bytes at the end of the cycle.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < eeprom_pkg::MEM_WORDS; i++) begin
        mem_q[i] <= '0;
      end
    end else if (ew_done) begin
      mem_q[wr_addr_q] <= wr_buf_q[0];
      if (commit_cnt_q == 2'h2) begin
        mem_q[ptr_next(wr_addr_q)] <= wr_buf_q[1];
      end
    end
  end

endmodule : serial_eeprom_i2c_slave

/* dv/eeprom_chk.sv */
`timescale 1ns/1ps

module eeprom_chk #(
  parameter int EW_BYTE_CYCLES = 1000
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic [eeprom_pkg::STRAP_W-1:0] chip_select_straps_i,
  input wire logic busy_o
);
  logic [7:0] low_age_q;
  logic [7:0] stop_age_q;
  logic [31:0] busy_len_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  // Counts cycles since the bus clock last fell.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) low_age_q <= 8'hff;
    else if ($fell(scl_i)) low_age_q <= 8'h00;
    else if (low_age_q != 8'hff) low_age_q <= low_age_q + 8'h01;
  end

  // Counts cycles since the last stop on the pins.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) stop_age_q <= 8'hff;
    else if (scl_i && $rose(sda_i)) stop_age_q <= 8'h00;
    else if (stop_age_q != 8'hff) stop_age_q <= stop_age_q + 8'h01;
  end

  // Counts the cycles of the current busy run.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) busy_len_q <= 32'h0;
    else if (busy_o) busy_len_q <= busy_len_q + 32'h1;
    else busy_len_q <= 32'h0;
  end

  sequence s_start;
    scl_i && $fell(sda_i);
  endsequence
  sequence s_drive_hold;
    sda_oe_o [*8];
  endsequence
  property p_oe_lag;
    $changed(sda_oe_o) |-> low_age_q >= 8'h0a && low_age_q <= 8'h1e;
  endproperty
  property p_busy_len;
    $fell(busy_o) |-> busy_len_q == EW_BYTE_CYCLES || busy_len_q == 2 * EW_BYTE_CYCLES;
  endproperty

  a_drive_low_only: assert property (sda_oe_o |-> !sda_o)
    else $error("data driven high");
  a_oe_change_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data drive changed while clock high");
  a_oe_lag_bound: assert property (p_oe_lag)
    else $error("data drive change not tied to clock fall");
  a_ack_hold_high: assert property ($rose(scl_i) && sda_oe_o |-> s_drive_hold)
    else $error("data drive dropped during clock high");
  a_start_release: assert property (s_start |-> !sda_oe_o [*8])
    else $error("data driven right after start");
  a_busy_from_stop: assert property ($rose(busy_o) |-> stop_age_q <= 8'h28)
    else $error("erase write began without stop");
  a_busy_length: assert property (p_busy_len)
    else $error("erase write length wrong");
  a_busy_refuse: assert property (busy_o |-> !sda_oe_o)
    else $error("data driven while busy");
endmodule : eeprom_chk

bind serial_eeprom_i2c_slave eeprom_chk #(.EW_BYTE_CYCLES(EW_BYTE_CYCLES)) u_chk (
  .clk_i(clk_i),
  .rstn_i(rstn_i),
  .scl_i(scl_i),
  .sda_i(sda_i),
  .sda_o(sda_o),
  .sda_oe_o(sda_oe_o),
  .chip_select_straps_i(chip_select_straps_i),
  .busy_o(busy_o)
);

/* dv/i2c_master_model.sv */
`timescale 1ns/1ps

module i2c_master_model (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  localparam int HALF = 50;

  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  // One clock pulse; data changes only while the clock is low.
  task automatic bit_x(input logic b, output logic r);
    tick(10);
    sda_low_o <= !b;
    tick(HALF);
    scl_o <= 1'b1;
    tick(HALF);
    r = sda_i;
    scl_o <= 1'b0;
  endtask : bit_x

  // A clock spike shorter than the input filter, sent while the clock is low.
  task automatic spike(input int n);
    tick(20);
    scl_o <= 1'b1;
    tick(n);
    scl_o <= 1'b0;
  endtask : spike

  task automatic start();
    tick(10);
    sda_low_o <= 1'b0;
    tick(HALF);
    scl_o <= 1'b1;
    tick(HALF);
    sda_low_o <= 1'b1;
    tick(HALF);
    scl_o <= 1'b0;
  endtask : start

  task automatic stop();
    tick(10);
    sda_low_o <= 1'b1;
    tick(HALF);
    scl_o <= 1'b1;
    tick(HALF);
    sda_low_o <= 1'b0;
    tick(HALF);
  endtask : stop

  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask : send

  task automatic recv(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(!ack, r);
  endtask : recv
endmodule : i2c_master_model

/* dv/tb_serial_eeprom_i2c_slave.sv */
`timescale 1ns/1ps

module tb_serial_eeprom_i2c_slave;
  localparam int EW = 1000;
  localparam logic [6:0] SLV = 7'h55;
  localparam logic [6:0] OTHER = 7'h54;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [2:0] straps = 3'h5;
  logic scl, m_low, sda_o, sda_oe_o, busy_o, ack;
  logic [7:0] d;
  wire sda;
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  int run_len = 0;
  int last_len = 0;

  assign sda = !(sda_oe_o | m_low);
  always #10 clk_i = ~clk_i;

  serial_eeprom_i2c_slave #(.EW_BYTE_CYCLES(EW)) dut (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .scl_i(scl),
    .sda_i(sda),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .chip_select_straps_i(straps),
    .busy_o(busy_o)
  );

  i2c_master_model m (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low));

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (busy_o === 1'b1) run_len <= run_len + 1;
    else if (run_len != 0) begin
      last_len <= run_len;
      run_len <= 0;
    end
    if (cyc == 90000) begin
      n_fail++;
      complete_run();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run

  task automatic addr(input logic [6:0] a, input logic r, input logic exp);
    m.start();
    m.send({a, r}, ack);
    check(ack, exp);
  endtask : addr

  task automatic wr(input logic [7:0] v, input logic exp);
    m.send(v, ack);
    check(ack, exp);
  endtask : wr

  task automatic rd(input logic a, input logic [7:0] exp);
    m.recv(a, d);
    check(d, exp);
  endtask : rd

  task automatic ew_done(input int n);
    repeat (3000) if (last_len == 0) @(posedge clk_i);
    check(last_len, n);
    last_len = 0;
  endtask : ew_done

  task automatic read_at(input logic [7:0] a, input logic [7:0] exp);
    addr(SLV, 1'b0, 1'b1);
    wr(a, 1'b1);
    addr(SLV, 1'b1, 1'b1);
    rd(1'b0, exp);
    m.stop();
  endtask : read_at

  task automatic t_write_pair();
    addr(SLV, 1'b0, 1'b1);
    wr(8'hff, 1'b1);
    wr(8'h3c, 1'b1);
    wr(8'h5a, 1'b1);
    wr(8'h77, 1'b0);
    check(busy_o, 1'b0);
    m.stop();
    addr(SLV, 1'b0, 1'b0);
    check(busy_o, 1'b1);
    m.stop();
    ew_done(2 * EW);
  endtask : t_write_pair

  task automatic t_random_read();
    addr(SLV, 1'b0, 1'b1);
    wr(8'hff, 1'b1);
    addr(SLV, 1'b1, 1'b1);
    rd(1'b1, 8'h3c);
    rd(1'b0, 8'h5a);
    m.stop();
    addr(SLV, 1'b1, 1'b1);
    rd(1'b1, 8'h5a);
    rd(1'b0, 8'h00);
    m.stop();
  endtask : t_random_read

  task automatic t_single();
    addr(SLV, 1'b0, 1'b1);
    wr(8'h10, 1'b1);
    m.spike(5);
    wr(8'ha5, 1'b1);
    m.stop();
    ew_done(EW);
    read_at(8'h10, 8'ha5);
  endtask : t_single

  task automatic t_mismatch();
    addr(OTHER, 1'b0, 1'b0);
    wr(8'h10, 1'b0);
    wr(8'h66, 1'b0);
    m.stop();
    m.tick(100);
    check(busy_o, 1'b0);
    read_at(8'h10, 8'ha5);
  endtask : t_mismatch

  initial begin
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    m.tick(30);
    t_write_pair();
    t_random_read();
    t_single();
    t_mismatch();
    complete_run();
  end
endmodule : tb_serial_eeprom_i2c_slave
